// ===== utcc_transfer_control.v
// Transfer control registers 0 and 1, mode, common and clock register configuration logic of one serial channel with an APB slave.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "utcc_map.vh"
// Function
// - Source 00 picks undivided or halved clock
// - Channel 1 flow pin needs both common bits 0
// - Flow disable releases pin to GPIO
// - Channel 2 outputs always open-drain; code holds P-channel off only from the first clock after reset
// - Channel 2 drive bit unused, write 0
// - Open-drain only holds P-channel off
// - Bit order acts in sync or 8-bit UART
// - Count source encodings, 11 prohibited
// - Serial mode encodings, others not allowed
// - Flow select 0 CTS, 1 RTS
module utcc_transfer_control #(
	parameter CHANNEL = 0,
	parameter ADDR_W = 12
) (
	input wire sys_clk,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire txRegEmpty,
	input wire txBufEmpty,
	output wire selUndivided,
	output wire selHalved,
	output wire selDivEight,
	output wire selDivThirtytwo,
	output wire modeSync,
	output wire modeI2c,
	output wire modeUart7,
	output wire modeUart8,
	output wire modeUart9,
	output wire flowCtsEnable,
	output wire flowRtsEnable,
	output wire flowPinGpio,
	output wire pchOffTransmit,
	output wire pchOffClock,
	output wire msbFirst,
	output wire clockPolarity,
	output wire transmitEnable,
	output wire receiveEnable
);
	localparam IS_CH2 = (CHANNEL == 2);
	localparam IS_CH1 = (CHANNEL == 1);
	// Only channel 1 shares its flow pin with the common control bits, so only it checks them.
	// ==========================================================================
	// Register storage
	reg [7:0] modeReg_ff;
	reg [7:0] ctrl0_ff;
	reg [7:0] ctrl1_ff;
	reg [7:0] commonReg_ff;
	reg [7:0] pclkReg_ff;
	reg pready_ff;
	reg pslverr_ff;
	reg [31:0] prdata_ff;
	reg [3:0] srcSel_ff;
	reg [4:0] modeSel_ff;
	reg [2:0] flow_ff;
	reg [1:0] pchOff_ff;
	reg msbFirst_ff;
	reg clockPolarity_ff;
	reg [1:0] enables_ff;
	// ==========================================================================
	// APB decode
	// Every transfer gets exactly one access cycle; the slave never adds wait states.
	wire setupPhase = psel & ~penable & ~pready_ff;
	wire doWrite = psel & penable & pready_ff & pwrite;
	wire hitMode = (paddr == `UTCC_ADDR_MODE);
	wire hitCtrl0 = (paddr == `UTCC_ADDR_CTRL0);
	wire hitCtrl1 = (paddr == `UTCC_ADDR_CTRL1);
	wire hitCommon = (paddr == `UTCC_ADDR_COMMON);
	wire hitPclk = (paddr == `UTCC_ADDR_PCLK);
	wire hitAny = hitMode | hitCtrl0 | hitCtrl1 | hitCommon | hitPclk;
	// ==========================================================================
	// Read view
	// Bits that the hardware owns are patched into the view, so a write cannot fake a status.
	reg [7:0] nxt_readByte;
	reg [7:0] ctrl0View;
	always @* begin
		ctrl0View = ctrl0_ff;
		ctrl0View[`UTCC_C0_TXEMPTY] = txRegEmpty;
		if (IS_CH2) begin
			ctrl0View[`UTCC_C0_DRIVE] = 1'b0;
		end
		nxt_readByte = 8'h00;
		if (hitMode) begin
			nxt_readByte = modeReg_ff;
		end else if (hitCtrl0) begin
			nxt_readByte = ctrl0View;
		end else if (hitCtrl1) begin
			nxt_readByte = ctrl1_ff;
			nxt_readByte[`UTCC_C1_TBEMPTY] = txBufEmpty;
		end else if (hitCommon) begin
			nxt_readByte = commonReg_ff;
		end else if (hitPclk) begin
			nxt_readByte = pclkReg_ff;
		end
	end
	// ==========================================================================
	// Bus answer
	// The answer is prepared at the setup edge so every bus output is a flop.
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= setupPhase;
			pslverr_ff <= setupPhase & ~hitAny;
			if (setupPhase) begin
				prdata_ff <= {24'h000000, nxt_readByte};
			end
		end
	end
	// ==========================================================================
	// Register writes
	// Unused and read-only control, common and clock bits are stored as constants; all eight mode register bits read back as written.
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			modeReg_ff <= `UTCC_RST_MODE;
			ctrl0_ff <= `UTCC_RST_CTRL0;
			ctrl1_ff <= `UTCC_RST_CTRL1;
			commonReg_ff <= `UTCC_RST_COMMON;
			pclkReg_ff <= `UTCC_RST_PCLK;
		end else if (doWrite) begin
			if (hitMode) begin
				modeReg_ff <= pwdata[7:0];
			end
			if (hitCtrl0) begin
				ctrl0_ff <= {pwdata[7:6], pwdata[5] & ~IS_CH2, pwdata[4], 1'b1, pwdata[2:0]};
			end
			if (hitCtrl1) begin
				ctrl1_ff <= {5'h00, pwdata[2], 1'b1, pwdata[0]};
			end
			if (hitCommon) begin
				commonReg_ff <= {6'h00, pwdata[1:0]};
			end
			if (hitPclk) begin
				pclkReg_ff <= {7'h00, pwdata[0]};
			end
		end
	end
	// ==========================================================================
	// Configuration decode
	wire [1:0] cntSel = ctrl0_ff[`UTCC_C0_CNT_HI:`UTCC_C0_CNT_LO];
	wire [2:0] serMode = modeReg_ff[2:0];
	wire fastPick = pclkReg_ff[`UTCC_PC_FAST];
	// Sources are not gated by software ordering; a late clock select change simply reroutes.
	// Code 11 selects no source at all, so a prohibited write stalls the divider instead.
	wire [3:0] nxt_srcSel = {
		cntSel == `UTCC_CNT_DIV32,
		cntSel == `UTCC_CNT_DIV8,
		(cntSel == `UTCC_CNT_BASE) & ~fastPick,
		(cntSel == `UTCC_CNT_BASE) & fastPick
	};
	wire [4:0] nxt_modeSel = {serMode == `UTCC_MODE_UART9, serMode == `UTCC_MODE_UART8,
		serMode == `UTCC_MODE_UART7, serMode == `UTCC_MODE_I2C,
		serMode == `UTCC_MODE_SYNC};
	// Channel 1 loses its flow pin once the common block hands it to channel 0 or the clock.
	wire flowAllowed = ~IS_CH1 | (~commonReg_ff[`UTCC_CM_CLKMODE]
		& ~commonReg_ff[`UTCC_CM_SEPARATE]);
	wire flowOn = flowAllowed & ~ctrl0_ff[`UTCC_C0_FLOWDIS];
	wire [2:0] nxt_flow = {~flowOn, flowOn & ctrl0_ff[`UTCC_C0_FLOWSEL],
		flowOn & ~ctrl0_ff[`UTCC_C0_FLOWSEL]};
	// Only the P-channel half is disabled; the pin keeps its N-channel pull-down drive.
	wire pchOff = IS_CH2 | ctrl0_ff[`UTCC_C0_DRIVE];
	// Two-wire mode always shifts the top bit first, whatever software left in the order bit.
	wire orderUsed = (serMode == `UTCC_MODE_SYNC) | (serMode == `UTCC_MODE_UART8);
	wire nxt_msb = orderUsed ? ctrl0_ff[`UTCC_C0_ORDER] : (serMode == `UTCC_MODE_I2C);
	// ==========================================================================
	// Output flops
	// Decoded outputs lag the registers by one clock, the price of driving every output from a flop.
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			srcSel_ff <= 4'h0;
			modeSel_ff <= 5'h00;
			flow_ff <= 3'h0;
			pchOff_ff <= 2'h0;
			msbFirst_ff <= 1'b0;
			clockPolarity_ff <= 1'b0;
			enables_ff <= 2'h0;
		end else begin
			srcSel_ff <= nxt_srcSel;
			modeSel_ff <= nxt_modeSel;
			flow_ff <= nxt_flow;
			pchOff_ff <= {pchOff, pchOff};
			msbFirst_ff <= nxt_msb;
			clockPolarity_ff <= ctrl0_ff[`UTCC_C0_CKPOL];
			enables_ff <= {ctrl1_ff[`UTCC_C1_RXEN], ctrl1_ff[`UTCC_C1_TXEN]};
		end
	end
	// ==========================================================================
	// Outputs
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign selUndivided = srcSel_ff[0];
	assign selHalved = srcSel_ff[1];
	assign selDivEight = srcSel_ff[2];
	assign selDivThirtytwo = srcSel_ff[3];
	assign modeSync = modeSel_ff[0];
	assign modeI2c = modeSel_ff[1];
	assign modeUart7 = modeSel_ff[2];
	assign modeUart8 = modeSel_ff[3];
	assign modeUart9 = modeSel_ff[4];
	assign flowCtsEnable = flow_ff[0];
	assign flowRtsEnable = flow_ff[1];
	assign flowPinGpio = flow_ff[2];
	assign pchOffTransmit = pchOff_ff[0];
	assign pchOffClock = pchOff_ff[1];
	assign msbFirst = msbFirst_ff;
	assign clockPolarity = clockPolarity_ff;
	assign transmitEnable = enables_ff[0];
	assign receiveEnable = enables_ff[1];
endmodule // utcc_transfer_control

// ===== utcc_map.vh
// Register addresses, field positions, reset values and encodings of the transfer control block.
`ifndef UTCC_MAP_VH
`define UTCC_MAP_VH
// ==========================================================================
// Register indices and byte addresses (byte address = 4 * index)
`define UTCC_IDX_MODE 12'h248
`define UTCC_IDX_CTRL0 12'h24c
`define UTCC_IDX_CTRL1 12'h24d
`define UTCC_IDX_COMMON 12'h250
`define UTCC_IDX_PCLK 12'h251
`define UTCC_ADDR_MODE 12'h920
`define UTCC_ADDR_CTRL0 12'h930
`define UTCC_ADDR_CTRL1 12'h934
`define UTCC_ADDR_COMMON 12'h940
`define UTCC_ADDR_PCLK 12'h944
// ==========================================================================
// Reset values
`define UTCC_RST_MODE 8'h00
`define UTCC_RST_CTRL0 8'h08
`define UTCC_RST_CTRL1 8'h02
`define UTCC_RST_COMMON 8'h00
`define UTCC_RST_PCLK 8'h00
// ==========================================================================
// Control register 0 fields
`define UTCC_C0_CNT_LO 0
`define UTCC_C0_CNT_HI 1
`define UTCC_C0_FLOWSEL 2
`define UTCC_C0_TXEMPTY 3
`define UTCC_C0_FLOWDIS 4
`define UTCC_C0_DRIVE 5
`define UTCC_C0_CKPOL 6
`define UTCC_C0_ORDER 7
// Control register 1 fields
`define UTCC_C1_TXEN 0
`define UTCC_C1_TBEMPTY 1
`define UTCC_C1_RXEN 2
// Common control and peripheral clock fields
`define UTCC_CM_CLKMODE 0
`define UTCC_CM_SEPARATE 1
`define UTCC_PC_FAST 0
// ==========================================================================
// Count source and serial mode encodings
`define UTCC_CNT_BASE 2'h0
`define UTCC_CNT_DIV8 2'h1
`define UTCC_CNT_DIV32 2'h2
`define UTCC_MODE_OFF 3'h0
`define UTCC_MODE_SYNC 3'h1
`define UTCC_MODE_I2C 3'h2
`define UTCC_MODE_UART7 3'h4
`define UTCC_MODE_UART8 3'h5
`define UTCC_MODE_UART9 3'h6
`endif

// ===== utcc_cfg_monitor.sv
// Checker for the decoded configuration outputs of the transfer control block.
`timescale 1ns/1ps
`include "utcc_map.vh"
module utcc_cfg_monitor (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic selUndivided,
	input wire logic selHalved,
	input wire logic selDivEight,
	input wire logic selDivThirtytwo,
	input wire logic modeSync,
	input wire logic modeI2c,
	input wire logic modeUart7,
	input wire logic modeUart8,
	input wire logic modeUart9,
	input wire logic flowCtsEnable,
	input wire logic flowRtsEnable,
	input wire logic flowPinGpio,
	input wire logic pchOffTransmit,
	input wire logic pchOffClock,
	input wire logic msbFirst
);
	// ==========================================================================
	// Assertions
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	wire wrDone = psel && penable && pready && pwrite;
	src_onehot_a: assert property (
		$onehot0({selUndivided, selHalved, selDivEight, selDivThirtytwo}))
		else $error("count source selects overlap");
	mode_onehot_a: assert property (
		$onehot0({modeSync, modeI2c, modeUart7, modeUart8, modeUart9}))
		else $error("serial mode decodes overlap");
	flow_onehot_a: assert property ($onehot0({flowCtsEnable, flowRtsEnable, flowPinGpio}))
		else $error("flow pin functions overlap");
	pch_pair_a: assert property (pchOffTransmit == pchOffClock)
		else $error("drive selects of data and clock differ");
	order_mode_a: assert property (msbFirst |-> modeSync || modeUart8 || modeI2c)
		else $error("bit order active in a mode without it");
	i2c_order_a: assert property (modeI2c |-> msbFirst)
		else $error("bit order not forced in two-wire mode");
	gpio_after_a: assert property (wrDone && paddr == `UTCC_ADDR_CTRL0 && pwdata[4]
		|-> ##2 flowPinGpio)
		else $error("flow disable did not release pin");
	i2c_after_a: assert property (wrDone && paddr == `UTCC_ADDR_MODE
		&& pwdata[2:0] == `UTCC_MODE_I2C |-> ##2 modeI2c)
		else $error("two-wire mode not decoded after write");
	answer_next_a: assert property (psel && !penable |=> pready)
		else $error("bus answer missing after setup");
	cover property (modeI2c && msbFirst);
	cover property (flowRtsEnable);
	cover property (selDivThirtytwo);
endmodule // utcc_cfg_monitor
bind utcc_transfer_control utcc_cfg_monitor utcc_cfg_monitor_inst (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.pready(pready),
	.paddr(paddr),
	.pwdata(pwdata),
	.selUndivided(selUndivided),
	.selHalved(selHalved),
	.selDivEight(selDivEight),
	.selDivThirtytwo(selDivThirtytwo),
	.modeSync(modeSync),
	.modeI2c(modeI2c),
	.modeUart7(modeUart7),
	.modeUart8(modeUart8),
	.modeUart9(modeUart9),
	.flowCtsEnable(flowCtsEnable),
	.flowRtsEnable(flowRtsEnable),
	.flowPinGpio(flowPinGpio),
	.pchOffTransmit(pchOffTransmit),
	.pchOffClock(pchOffClock),
	.msbFirst(msbFirst)
);

// ===== utcc_peer_model.sv
// Far-side serial peer model that reports transmitter status levels.
`timescale 1ns/1ps
module utcc_peer_model (
	input wire logic sys_clk,
	input wire logic busy,
	input wire logic queued,
	output logic txRegEmpty = 1'b1,
	output logic txBufEmpty = 1'b1
);
	// Status lags the far-side state by one clock, as a real shifter would.
	// Shift register and buffer empty apart, so a swapped status flag would show.
	always @(posedge sys_clk) begin
		txRegEmpty <= !busy;
		txBufEmpty <= !queued;
	end
endmodule // utcc_peer_model

// ===== tb.sv
// Self-checking bench for the transfer control block on channels 1 and 2.
`timescale 1ns/1ps
module tb;
	logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, busy = 0, queued = 0, e;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic pready, pslverr, txRegEmpty, txBufEmpty, pready2, pslverr2, e2, k2;
	logic [17:0] outs, outs2;
	logic [31:0] prdata2, rd2;
	logic [7:0] md = 0, c0 = 0, c1 = 0, com = 0, pc = 0, d;
	logic [11:0] adr[6] = '{12'h920, 12'h930, 12'h934, 12'h940, 12'h944, 12'h9f0};
	logic [7:0] rm[6] = '{8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
	logic [2:0] lm[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
	int nErrors = 0, numChecks = 0, cyc = 0, a;
	always #10 sys_clk = !sys_clk;
	utcc_peer_model utcc_peer_model_inst (.sys_clk(sys_clk), .busy(busy), .queued(queued),
		.txRegEmpty(txRegEmpty), .txBufEmpty(txBufEmpty));
	utcc_transfer_control #(.CHANNEL(1)) utcc_transfer_control_inst (.sys_clk(sys_clk),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.txRegEmpty(txRegEmpty), .txBufEmpty(txBufEmpty), .selUndivided(outs[17]),
		.selHalved(outs[16]), .selDivEight(outs[15]), .selDivThirtytwo(outs[14]),
		.modeSync(outs[13]), .modeI2c(outs[12]), .modeUart7(outs[11]), .modeUart8(outs[10]),
		.modeUart9(outs[9]), .flowCtsEnable(outs[8]), .flowRtsEnable(outs[7]),
		.flowPinGpio(outs[6]), .pchOffTransmit(outs[5]), .pchOffClock(outs[4]),
		.msbFirst(outs[3]), .clockPolarity(outs[2]), .transmitEnable(outs[1]),
		.receiveEnable(outs[0]));
	// Channel 2 shares the bus; software keeps its unused drive bit at 0.
	utcc_transfer_control #(.CHANNEL(2)) utcc_transfer_control_ch2_inst (.sys_clk(sys_clk),
		.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata & 32'hffffffdf),
		.prdata(prdata2), .pready(pready2), .pslverr(pslverr2),
		.txRegEmpty(txRegEmpty), .txBufEmpty(txBufEmpty), .selUndivided(outs2[17]),
		.selHalved(outs2[16]), .selDivEight(outs2[15]), .selDivThirtytwo(outs2[14]),
		.modeSync(outs2[13]), .modeI2c(outs2[12]), .modeUart7(outs2[11]), .modeUart8(outs2[10]),
		.modeUart9(outs2[9]), .flowCtsEnable(outs2[8]), .flowRtsEnable(outs2[7]),
		.flowPinGpio(outs2[6]), .pchOffTransmit(outs2[5]), .pchOffClock(outs2[4]),
		.msbFirst(outs2[3]), .clockPolarity(outs2[2]), .transmitEnable(outs2[1]),
		.receiveEnable(outs2[0]));
	// ==========================================================================
	// Tasks and reference model
	task automatic close_out();
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		numChecks++;
		if (g !== x) begin
			nErrors++;
			$display("unexpected at %0t: got %h, want %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] dt,
		output logic [31:0] r, output logic er);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h0, dt};
		@(posedge sys_clk);
		penable <= 1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		// Both slaves see the same request, so both answer at this same edge.
		r = prdata;
		er = pslverr;
		rd2 = prdata2;
		e2 = pslverr2;
		k2 = pready2;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask
	function automatic logic [17:0] expo(input int ch);
		logic [2:0] m;
		logic off;
		logic pch;
		m = md[2:0];
		off = c0[4] | (ch == 1 && com[1:0] != 2'h0);
		pch = ch == 2 || c0[5];
		return {c0[1:0] == 0 && pc[0], c0[1:0] == 0 && !pc[0], c0[1:0] == 1, c0[1:0] == 2,
			m == 1, m == 2, m == 4, m == 5, m == 6, !off && !c0[2], !off && c0[2], off,
			pch, pch, (m == 1 || m == 5) ? c0[7] : m == 2, c0[6], c1[0], c1[2]};
	endfunction
	function automatic logic [7:0] expr(input int k, input int ch);
		logic [7:0] v[6];
		logic [7:0] view0;
		view0 = (ch == 2) ? (c0 & 8'hdf) : c0;
		v = '{md, view0 | (busy ? 8'h00 : 8'h08), c1 | (queued ? 8'h00 : 8'h02), com, pc, 8'h00};
		return v[k];
	endfunction
	always @(posedge sys_clk) if (++cyc > 20000) begin
		nErrors++;
		close_out();
	end
	// ==========================================================================
	// Main sequence: reset values first, then random writes with read-back.
	initial begin
		void'($urandom(32'hf197));
		repeat (8) @(posedge sys_clk);
		reset_n <= 1;
		for (int i = 0; i < 246; i++) begin
			a = i % 6;
			d = 8'($urandom);
			if (a == 0) d[2:0] = lm[$urandom % 6];
			if (a == 1) d[1:0] = 2'($urandom % 3);
			if (a == 1 && md[2:0] == 3'h2) d[7] = 1'b1;
			if (a == 1 && (md[2:0] == 3'h4 || md[2:0] == 3'h6)) d[7] = 1'b0;
			// Clock selects are settled before the first count source write.
			if (i == 6) begin
				apb(1, adr[4], 8'h00, rd, e);
				chk(e, 0);
			end
			if (i >= 6) begin
				busy <= 1'($urandom);
				queued <= 1'($urandom);
				apb(1, adr[a], d, rd, e);
				chk(e, a == 5);
				chk(e2, a == 5);
				chk(k2, 1);
				case (a)
					0: md = d & 8'h07;
					// The divisor sits outside this block, so no rewrite follows a source change.
					1: c0 = d & 8'hf7;
					2: c1 = d & 8'h05;
					3: com = d & 8'h03;
					4: pc = d & 8'h01;
					default: ;
				endcase
			end
			apb(0, adr[a], 8'h00, rd, e);
			chk(e, a == 5);
			chk(e2, a == 5);
			chk(k2, 1);
			chk(rd & {24'hffffff, rm[a]}, expr(a, 1));
			chk(rd2 & {24'hffffff, rm[a]}, expr(a, 2));
			chk(outs, expo(1));
			chk(outs2, expo(2));
		end
		close_out();
	end
endmodule // tb
